// ---- verilog/fco_unit.v ----
// Single-precision compare, sign, multiply, subtract and square root unit.
// Notes on behaviour
// - geq gives 1 when first operand at least second; one cycle, slot 3.
// - gtr gives 1 when first operand exceeds second; one cycle, slot 3.
// - neq gives 1 when operands differ, 0 when equal; one cycle, slot 3.
// - sign gives 0 for zero, all ones negative, 1 positive; one cycle.
// - compare and sign flag variants return IEEE flags, same timing.
// - multiply or its flags after 3 cycles, slot 2 or 3.
// - square root after 17 cycles, slot 2, no new issue for 16 cycles.
// - square root flags variant has the same latency, slot and recovery.
// - subtract a minus b or its flags after 3 cycles, slot 1 or 4.
`timescale 1ns/1ps
`include "fco_defs.vh"
module fco_unit (
  input wire sys_clk,
  input wire rst,
  input wire cmp_valid,
  input wire [2:0] cmp_slot,
  input wire [1:0] cmp_op,
  input wire cmp_flags_sel,
  input wire [31:0] cmp_a,
  input wire [31:0] cmp_b,
  output reg cmp_done,
  output reg [31:0] cmp_result,
  input wire mul_valid,
  input wire [2:0] mul_slot,
  input wire mul_flags_sel,
  input wire [31:0] mul_a,
  input wire [31:0] mul_b,
  output reg mul_done,
  output reg [31:0] mul_result,
  input wire sub_valid,
  input wire [2:0] sub_slot,
  input wire sub_flags_sel,
  input wire [31:0] sub_a,
  input wire [31:0] sub_b,
  output reg sub_done,
  output reg [31:0] sub_result,
  input wire sqrt_valid,
  input wire [2:0] sqrt_slot,
  input wire sqrt_flags_sel,
  input wire [31:0] sqrt_a,
  output wire sqrt_done,
  output wire [31:0] sqrt_result,
  output wire sqrt_busy
);
  function is_nan;
    input [31:0] x;
    begin
      is_nan = (x[30:23] == `FCO_EXP_MAX) && (x[22:0] != 23'h0);
    end
  endfunction

  function is_snan;
    input [31:0] x;
    begin
      is_snan = is_nan(x) && !x[22];
    end
  endfunction

  // Subnormals are flushed, so any zero exponent counts as zero.
  function is_zero;
    input [31:0] x;
    begin
      is_zero = (x[30:23] == 8'h00);
    end
  endfunction

  function is_inf;
    input [31:0] x;
    begin
      is_inf = (x[30:23] == `FCO_EXP_MAX) && (x[22:0] == 23'h0);
    end
  endfunction

  // Monotonic unsigned key; both zeros map to one key so -0 equals +0.
  function [31:0] ord_key;
    input [31:0] x;
    begin
      if (is_zero(x)) begin
        ord_key = `FCO_ZERO_KEY;
      end else if (x[31]) begin
        ord_key = ~x;
      end else begin
        ord_key = x | `FCO_ZERO_KEY;
      end
    end
  endfunction

  function [4:0] lzc;
    input [26:0] v;
    integer k;
    reg found;
    begin
      lzc = 5'h00;
      found = 1'b0;
      for (k = 26; k >= 0; k = k - 1) begin
        if (!found) begin
          if (v[k]) begin
            found = 1'b1;
          end else begin
            lzc = lzc + 5'h01;
          end
        end
      end
    end
  endfunction

  // Round to nearest even; m holds 24 mantissa bits, guard, round, sticky.
  function [36:0] round_pack;
    input s;
    input [9:0] e;
    input [26:0] m;
    reg [24:0] r;
    reg [9:0] ee;
    reg [4:0] fl;
    begin
      r = {1'b0, m[26:3]} + {24'h0, m[2] & (m[1] | m[0] | m[3])};
      ee = e;
      fl = 5'h00;
      fl[`FCO_F_INX] = m[2] | m[1] | m[0];
      if (r[24]) begin
        r = {1'b0, r[24:1]};
        ee = e + 10'h001;
      end
      if (ee[9] || ee == 10'h000) begin
        fl[`FCO_F_UNF] = 1'b1;
        fl[`FCO_F_INX] = 1'b1;
        round_pack = {fl, s, 31'h0};
      end else if (ee >= {2'b00, `FCO_EXP_MAX}) begin
        fl[`FCO_F_OVF] = 1'b1;
        fl[`FCO_F_INX] = 1'b1;
        round_pack = {fl, s, `FCO_EXP_MAX, 23'h0};
      end else begin
        round_pack = {fl, s, ee[7:0], r[22:0]};
      end
    end
  endfunction

  reg [31:0] cmp_val;
  reg [4:0] cmp_fl;
  wire cmp_take;
  wire [31:0] ka;
  wire [31:0] kb;
  wire ordered;

  assign cmp_take = cmp_valid && (cmp_slot == `FCO_SLOT_CMP);
  assign ka = ord_key(cmp_a);
  assign kb = ord_key(cmp_b);
  assign ordered = !is_nan(cmp_a) && !is_nan(cmp_b);

  always @* begin
    cmp_val = 32'h0;
    cmp_fl = 5'h00;
    case (cmp_op)
      `FCO_OP_GEQ: begin
        cmp_val = {31'h0, ordered && (ka >= kb)};
        cmp_fl[`FCO_F_INV] = !ordered;
      end
      `FCO_OP_GTR: begin
        cmp_val = {31'h0, ordered && (ka > kb)};
        cmp_fl[`FCO_F_INV] = !ordered;
      end
      `FCO_OP_NEQ: begin
        cmp_val = {31'h0, !ordered || (ka != kb)};
        cmp_fl[`FCO_F_INV] = is_snan(cmp_a) || is_snan(cmp_b);
      end
      default: begin
        if (is_zero(cmp_a)) begin
          cmp_val = 32'h0;
        end else if (cmp_a[31]) begin
          cmp_val = `FCO_MINUS_ONE;
        end else begin
          cmp_val = `FCO_PLUS_ONE;
        end
        cmp_fl[`FCO_F_INV] = is_snan(cmp_a);
      end
    endcase
  end

  always @(posedge sys_clk) begin
    if (rst) begin
      cmp_done <= 1'b0;
      cmp_result <= 32'h0;
    end else begin
      cmp_done <= cmp_take;
      if (cmp_take) begin
        cmp_result <= cmp_flags_sel ? {27'h0, cmp_fl} : cmp_val;
      end
    end
  end

  // Multiply: product, normalise and round, then the output stage.
  reg m1_v, m1_fs, m1_s, m1_spec, m2_v, m2_fs;
  reg [9:0] m1_e;
  reg [47:0] m1_p;
  reg [36:0] m1_sres;
  reg [36:0] m2_res;
  wire mul_take;
  wire mul_inv;

  // multiply from slot 2 or 3
  assign mul_take = mul_valid &&
    (mul_slot == `FCO_SLOT_MUL_A || mul_slot == `FCO_SLOT_MUL_B);
  assign mul_inv = is_snan(mul_a) || is_snan(mul_b) ||
    (is_inf(mul_a) && is_zero(mul_b)) || (is_zero(mul_a) && is_inf(mul_b));

  // Subtract: align and add, normalise and round, then the output stage.
  reg s1_v, s1_fs, s1_s, s1_spec, s2_v, s2_fs;
  reg [9:0] s1_e;
  reg [27:0] s1_sum;
  reg [36:0] s1_sres;
  reg [36:0] s2_res;
  reg [4:0] s_lz;
  reg [26:0] s_norm;
  reg [26:0] small_al;
  reg [7:0] s_d;
  reg [31:0] big;
  reg [31:0] lesser;
  wire sub_take;
  wire [31:0] nb;

  // subtract from slot 1 or 4
  assign sub_take = sub_valid &&
    (sub_slot == `FCO_SLOT_SUB_A || sub_slot == `FCO_SLOT_SUB_B);
  // a minus b is a plus negated b
  assign nb = {~sub_b[31], sub_b[30:0]};

  always @* begin
    if (sub_a[30:0] >= nb[30:0]) begin
      big = sub_a;
      lesser = nb;
    end else begin
      big = nb;
      lesser = sub_a;
    end
    s_d = big[30:23] - lesser[30:23];
    if (s_d >= 8'h1b) begin
      small_al = 27'h1;
    end else begin
      small_al = ({1'b1, lesser[22:0], 3'h0} >> s_d) |
        {26'h0, ({1'b1, lesser[22:0], 3'h0} &
        ~(27'h7ffffff << s_d)) != 27'h0};
    end
    s_lz = lzc(s1_sum[26:0]);
    s_norm = s1_sum[26:0] << s_lz;
  end

  always @(posedge sys_clk) begin
    if (rst) begin
      m1_v <= 1'b0;
      m1_fs <= 1'b0;
      m1_s <= 1'b0;
      m1_spec <= 1'b0;
      m1_e <= 10'h0;
      m1_p <= 48'h0;
      m1_sres <= 37'h0;
      m2_v <= 1'b0;
      m2_fs <= 1'b0;
      m2_res <= 37'h0;
      mul_done <= 1'b0;
      mul_result <= 32'h0;
      s1_v <= 1'b0;
      s1_fs <= 1'b0;
      s1_s <= 1'b0;
      s1_spec <= 1'b0;
      s1_e <= 10'h0;
      s1_sum <= 28'h0;
      s1_sres <= 37'h0;
      s2_v <= 1'b0;
      s2_fs <= 1'b0;
      s2_res <= 37'h0;
      sub_done <= 1'b0;
      sub_result <= 32'h0;
    end else begin
      m1_v <= mul_take;
      m1_fs <= mul_flags_sel;
      m1_s <= mul_a[31] ^ mul_b[31];
      m1_e <= {2'b00, mul_a[30:23]} + {2'b00, mul_b[30:23]} - `FCO_BIAS;
      m1_p <= {1'b1, mul_a[22:0]} * {1'b1, mul_b[22:0]};
      m1_spec <= 1'b1;
      if (is_nan(mul_a) || is_nan(mul_b) || mul_inv) begin
        m1_sres <= {mul_inv, 4'h0, `FCO_QNAN};
      end else if (is_inf(mul_a) || is_inf(mul_b)) begin
        m1_sres <= {5'h00, mul_a[31] ^ mul_b[31], `FCO_EXP_MAX, 23'h0};
      end else if (is_zero(mul_a) || is_zero(mul_b)) begin
        m1_sres <= {5'h00, mul_a[31] ^ mul_b[31], 31'h0};
      end else begin
        m1_spec <= 1'b0;
        m1_sres <= 37'h0;
      end
      m2_v <= m1_v;
      m2_fs <= m1_fs;
      if (m1_spec) begin
        m2_res <= m1_sres;
      end else if (m1_p[47]) begin
        m2_res <= round_pack(m1_s, m1_e + 10'h001,
          {m1_p[47:22], m1_p[21:0] != 22'h0});
      end else begin
        m2_res <= round_pack(m1_s, m1_e, {m1_p[46:21], m1_p[20:0] != 21'h0});
      end
      mul_done <= m2_v;
      mul_result <= m2_fs ? {27'h0, m2_res[36:32]} : m2_res[31:0];
      s1_v <= sub_take;
      s1_fs <= sub_flags_sel;
      s1_s <= big[31];
      s1_e <= {2'b00, big[30:23]};
      if (big[31] == lesser[31]) begin
        s1_sum <= {1'b0, 1'b1, big[22:0], 3'h0} + {1'b0, small_al};
      end else begin
        s1_sum <= {1'b0, 1'b1, big[22:0], 3'h0} - {1'b0, small_al};
      end
      s1_spec <= 1'b1;
      if (is_nan(sub_a) || is_nan(nb)) begin
        s1_sres <= {is_snan(sub_a) || is_snan(nb), 4'h0, `FCO_QNAN};
      end else if (is_inf(sub_a) && is_inf(nb) && (sub_a[31] != nb[31])) begin
        s1_sres <= {1'b1, 4'h0, `FCO_QNAN};
      end else if (is_inf(sub_a)) begin
        s1_sres <= {5'h00, sub_a};
      end else if (is_inf(nb)) begin
        s1_sres <= {5'h00, nb};
      end else if (is_zero(sub_a) && is_zero(nb)) begin
        s1_sres <= {5'h00, sub_a[31] & nb[31], 31'h0};
      end else if (is_zero(nb)) begin
        s1_sres <= {5'h00, sub_a};
      end else if (is_zero(sub_a)) begin
        s1_sres <= {5'h00, nb};
      end else begin
        s1_spec <= 1'b0;
        s1_sres <= 37'h0;
      end
      s2_v <= s1_v;
      s2_fs <= s1_fs;
      if (s1_spec) begin
        s2_res <= s1_sres;
      end else if (s1_sum == 28'h0) begin
        // Exact cancellation gives plus zero under round to nearest.
        s2_res <= 37'h0;
      end else if (s1_sum[27]) begin
        s2_res <= round_pack(s1_s, s1_e + 10'h001,
          {s1_sum[27:2], s1_sum[1] | s1_sum[0]});
      end else begin
        s2_res <= round_pack(s1_s, s1_e - {5'h00, s_lz}, s_norm);
      end
      sub_done <= s2_v;
      sub_result <= s2_fs ? {27'h0, s2_res[36:32]} : s2_res[31:0];
    end
  end

  fco_sqrt u_sqrt (
    .sys_clk(sys_clk),
    .rst(rst),
    .req(sqrt_valid && (sqrt_slot == `FCO_SLOT_SQRT)),
    .flags_sel(sqrt_flags_sel),
    .src(sqrt_a),
    .done(sqrt_done),
    .result(sqrt_result),
    .busy(sqrt_busy)
  );
endmodule

// ---- verilog/fco_defs.vh ----
// Constants shared by the floating-point operation units.
`ifndef FCO_DEFS_VH
`define FCO_DEFS_VH
`define FCO_EXP_MAX 8'hff
`define FCO_BIAS 10'h07f
`define FCO_BIAS9 9'h07f
`define FCO_QNAN 32'h7fc00000
`define FCO_ZERO_KEY 32'h80000000
`define FCO_MINUS_ONE 32'hffffffff
`define FCO_PLUS_ONE 32'h00000001
`define FCO_F_INX 0
`define FCO_F_UNF 1
`define FCO_F_OVF 2
`define FCO_F_DBZ 3
`define FCO_F_INV 4
`define FCO_OP_GEQ 2'h0
`define FCO_OP_GTR 2'h1
`define FCO_OP_NEQ 2'h2
`define FCO_OP_SIGN 2'h3
`define FCO_SLOT_CMP 3'h3
`define FCO_SLOT_MUL_A 3'h2
`define FCO_SLOT_MUL_B 3'h3
`define FCO_SLOT_SUB_A 3'h1
`define FCO_SLOT_SUB_B 3'h4
`define FCO_SLOT_SQRT 3'h2
`define FCO_SQRT_LAT 5'h11
`define FCO_SQRT_RECOVERY 5'h10
`define FCO_SQRT_ITER 5'h0d
`endif

// ---- verilog/fco_sqrt.v ----
// Long-latency single-precision square root with status flags.
`timescale 1ns/1ps
`include "fco_defs.vh"
module fco_sqrt (
  input wire sys_clk,
  input wire rst,
  input wire req,
  input wire flags_sel,
  input wire [31:0] src,
  output reg done,
  output reg [31:0] result,
  output reg busy
);
  reg [4:0] cnt;
  reg [51:0] rad;
  reg [29:0] rem;
  reg [25:0] root;
  reg [7:0] res_exp;
  reg spec;
  reg [36:0] spec_res;
  reg fsel;
  reg [51:0] next_rad;
  reg [29:0] next_rem;
  reg [25:0] next_root;
  reg [29:0] t;
  reg [29:0] trial;
  reg [24:0] rnd;
  reg [4:0] fl;
  reg [36:0] fin;
  reg inc;
  reg sticky;
  integer i;
  wire take;
  wire a_nan;
  wire a_zero;
  wire [23:0] mant;
  wire [8:0] exp_sum;

  assign take = req && !busy;
  assign a_nan = (src[30:23] == `FCO_EXP_MAX) && (src[22:0] != 23'h0);
  assign a_zero = (src[30:23] == 8'h00);
  assign mant = {1'b1, src[22:0]};
  assign exp_sum = {1'b0, src[30:23]} + `FCO_BIAS9;

  // Two root bits per cycle gives 26 bits in thirteen cycles.
  always @* begin
    next_rad = rad;
    next_rem = rem;
    next_root = root;
    t = 30'h0;
    trial = 30'h0;
    for (i = 0; i < 2; i = i + 1) begin
      t = {next_rem[27:0], next_rad[51:50]};
      trial = {2'b00, next_root, 2'b01};
      next_rad = {next_rad[49:0], 2'b00};
      if (t >= trial) begin
        next_rem = t - trial;
        next_root = {next_root[24:0], 1'b1};
      end else begin
        next_rem = t;
        next_root = {next_root[24:0], 1'b0};
      end
    end
  end

  always @* begin
    sticky = (rem != 30'h0);
    inc = root[1] & (root[0] | sticky | root[2]);
    rnd = {1'b0, root[25:2]} + {24'h0, inc};
    fl = 5'h00;
    fl[`FCO_F_INX] = root[1] | root[0] | sticky;
    if (rnd[24]) begin
      fin = {fl, 1'b0, res_exp + 8'h01, 23'h0};
    end else begin
      fin = {fl, 1'b0, res_exp, rnd[22:0]};
    end
    if (spec) begin
      fin = spec_res;
    end
  end

  always @(posedge sys_clk) begin
    if (rst) begin
      cnt <= 5'h00;
      rad <= 52'h0;
      rem <= 30'h0;
      root <= 26'h0;
      res_exp <= 8'h00;
      spec <= 1'b0;
      spec_res <= 37'h0;
      fsel <= 1'b0;
      done <= 1'b0;
      result <= 32'h0;
      busy <= 1'b0;
    end else begin
      busy <= take || (cnt != 5'h00 && cnt < `FCO_SQRT_RECOVERY - 5'h01);
      done <= (cnt == `FCO_SQRT_LAT - 5'h01);
      if (cnt == `FCO_SQRT_LAT - 5'h01) begin
        result <= fsel ? {27'h0, fin[36:32]} : fin[31:0];
      end
      if (take) begin
        cnt <= 5'h01;
        fsel <= flags_sel;
        rem <= 30'h0;
        root <= 26'h0;
        res_exp <= exp_sum[8:1];
        rad <= src[23] ? {1'b0, mant, 27'h0} : {mant, 28'h0};
        spec <= 1'b1;
        if (a_nan) begin
          spec_res <= {~src[22], 4'h0, `FCO_QNAN};
        end else if (a_zero) begin
          spec_res <= {5'h00, src[31], 31'h0};
        end else if (src[31]) begin
          spec_res <= {1'b1, 4'h0, `FCO_QNAN};
        end else if (src[30:23] == `FCO_EXP_MAX) begin
          spec_res <= {5'h00, src};
        end else begin
          spec <= 1'b0;
          spec_res <= 37'h0;
        end
      end else begin
        if (cnt != 5'h00 && cnt < `FCO_SQRT_LAT - 5'h01) begin
          cnt <= cnt + 5'h01;
        end else begin
          cnt <= 5'h00;
        end
        if (cnt != 5'h00 && cnt <= `FCO_SQRT_ITER) begin
          rad <= next_rad;
          rem <= next_rem;
          root <= next_root;
        end
      end
    end
  end
endmodule

// ---- tb/fco_unit_assertions.sv ----
// Concurrent checks on the ports of the floating-point operation unit.
`timescale 1ns/1ps
module fco_unit_assertions (
  input wire sys_clk,
  input wire rst,
  input wire cmp_valid,
  input wire [2:0] cmp_slot,
  input wire [1:0] cmp_op,
  input wire cmp_flags_sel,
  input wire cmp_done,
  input wire [31:0] cmp_result,
  input wire mul_valid,
  input wire [2:0] mul_slot,
  input wire mul_flags_sel,
  input wire mul_done,
  input wire [31:0] mul_result,
  input wire sub_valid,
  input wire [2:0] sub_slot,
  input wire sub_done,
  input wire sqrt_valid,
  input wire [2:0] sqrt_slot,
  input wire sqrt_done,
  input wire sqrt_busy
);
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (rst);
  AST_CMP_LAT: assert property (
    cmp_valid && cmp_slot == 3'h3 |=> cmp_done)
    else $error("compare done missing");
  AST_CMP_REFUSE: assert property (
    !(cmp_valid && cmp_slot == 3'h3) |=> !cmp_done)
    else $error("compare done without request");
  AST_CMP_BOOL: assert property (
    cmp_done && !$past(cmp_flags_sel) && $past(cmp_op) != 2'h3
    |-> cmp_result[31:1] == 31'h0)
    else $error("compare result not boolean");
  AST_SIGN: assert property (
    cmp_done && !$past(cmp_flags_sel) && $past(cmp_op) == 2'h3
    |-> cmp_result inside {32'h0, 32'h1, 32'hffffffff})
    else $error("sign result out of range");
  AST_CMP_FLAGS: assert property (
    cmp_done && $past(cmp_flags_sel)
    |-> cmp_result[31:5] == 27'h0 && !cmp_result[3])
    else $error("compare flags word malformed");
  AST_MUL_LAT: assert property (
    mul_valid && (mul_slot == 3'h2 || mul_slot == 3'h3) |-> ##3 mul_done)
    else $error("multiply done late");
  AST_MUL_FLAGS: assert property (
    mul_done && $past(mul_flags_sel, 3) |-> mul_result[31:5] == 27'h0)
    else $error("multiply flags word malformed");
  AST_SUB_LAT: assert property (
    sub_valid && (sub_slot == 3'h1 || sub_slot == 3'h4) |-> ##3 sub_done)
    else $error("subtract done late");
  AST_SQRT_LAT: assert property (
    sqrt_valid && sqrt_slot == 3'h2 && !sqrt_busy |-> ##17 sqrt_done)
    else $error("root done late");
  AST_SQRT_BUSY: assert property (
    sqrt_valid && sqrt_slot == 3'h2 && !sqrt_busy
    |=> sqrt_busy[*8] ##1 sqrt_busy[*7] ##1 !sqrt_busy)
    else $error("root recovery window wrong");
endmodule
bind fco_unit fco_unit_assertions fco_unit_assertions_inst (
  .sys_clk(sys_clk), .rst(rst), .cmp_valid(cmp_valid), .cmp_slot(cmp_slot),
  .cmp_op(cmp_op), .cmp_flags_sel(cmp_flags_sel), .cmp_done(cmp_done),
  .cmp_result(cmp_result), .mul_valid(mul_valid), .mul_slot(mul_slot),
  .mul_flags_sel(mul_flags_sel), .mul_done(mul_done),
  .mul_result(mul_result), .sub_valid(sub_valid), .sub_slot(sub_slot),
  .sub_done(sub_done), .sqrt_valid(sqrt_valid), .sqrt_slot(sqrt_slot),
  .sqrt_done(sqrt_done), .sqrt_busy(sqrt_busy));

// ---- tb/fco_issuer.sv ----
// Issue-side model that places square-root work on the long unit.
`timescale 1ns/1ps
module fco_issuer (
  input wire sys_clk,
  input wire sqrt_busy,
  output reg sqrt_valid,
  output reg [2:0] sqrt_slot,
  output reg sqrt_flags_sel,
  output reg [31:0] sqrt_a
);
  initial begin
    sqrt_valid = 1'b0;
    sqrt_slot = 3'h0;
    sqrt_flags_sel = 1'b0;
    sqrt_a = 32'h0;
  end
  // Clearing wait_free breaks the spacing on purpose to provoke a refusal.
  task issue(input logic fl, input logic [31:0] a, input logic wait_free);
    begin
      @(posedge sys_clk);
      #1;
      while (wait_free && sqrt_busy === 1'b1) begin
        @(posedge sys_clk);
        #1;
      end
      sqrt_valid = 1'b1;
      sqrt_slot = 3'h2;
      sqrt_flags_sel = fl;
      sqrt_a = a;
      @(posedge sys_clk);
      #1;
      sqrt_valid = 1'b0;
      sqrt_a = ~a;
    end
  endtask
endmodule

// ---- tb/tb_top.sv ----
// Self-checking bench for the floating-point operation unit.
`timescale 1ns/1ps
module tb_top;
  logic sys_clk, rst, cmp_valid, cmp_flags_sel, mul_valid, mul_flags_sel;
  logic sub_valid, sub_flags_sel, sqrt_valid, sqrt_flags_sel;
  logic [2:0] cmp_slot, mul_slot, sub_slot, sqrt_slot;
  logic [1:0] cmp_op;
  logic [31:0] cmp_a, cmp_b, mul_a, mul_b, sub_a, sub_b, sqrt_a;
  wire cmp_done, mul_done, sub_done, sqrt_done, sqrt_busy;
  wire [31:0] cmp_result, mul_result, sub_result, sqrt_result;
  int errors = 0;
  int tests_run = 0;
  fco_unit fco_unit_inst (.sys_clk(sys_clk), .rst(rst),
    .cmp_valid(cmp_valid), .cmp_slot(cmp_slot), .cmp_op(cmp_op),
    .cmp_flags_sel(cmp_flags_sel), .cmp_a(cmp_a), .cmp_b(cmp_b),
    .cmp_done(cmp_done), .cmp_result(cmp_result), .mul_valid(mul_valid),
    .mul_slot(mul_slot), .mul_flags_sel(mul_flags_sel), .mul_a(mul_a),
    .mul_b(mul_b), .mul_done(mul_done), .mul_result(mul_result),
    .sub_valid(sub_valid), .sub_slot(sub_slot),
    .sub_flags_sel(sub_flags_sel), .sub_a(sub_a), .sub_b(sub_b),
    .sub_done(sub_done), .sub_result(sub_result), .sqrt_valid(sqrt_valid),
    .sqrt_slot(sqrt_slot), .sqrt_flags_sel(sqrt_flags_sel),
    .sqrt_a(sqrt_a), .sqrt_done(sqrt_done), .sqrt_result(sqrt_result),
    .sqrt_busy(sqrt_busy));
  fco_issuer fco_issuer_inst (.sys_clk(sys_clk), .sqrt_busy(sqrt_busy),
    .sqrt_valid(sqrt_valid), .sqrt_slot(sqrt_slot),
    .sqrt_flags_sel(sqrt_flags_sel), .sqrt_a(sqrt_a));
  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end
  task check(input string what, input logic [31:0] seen,
      input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      errors++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task stop_test;
    $display("errors %0d tests_run %0d", errors, tests_run);
    if (errors == 0 && tests_run > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  task cmp_case(input logic [1:0] op, input logic fl, input logic [2:0] slot,
      input logic [31:0] a, input logic [31:0] b, input logic [31:0] exp);
    @(posedge sys_clk);
    #1;
    cmp_valid = 1'b1;
    cmp_slot = slot;
    cmp_op = op;
    cmp_flags_sel = fl;
    cmp_a = a;
    cmp_b = b;
    @(posedge sys_clk);
    #1;
    cmp_valid = 1'b0;
    cmp_a = ~a;
    cmp_b = ~b;
    check("cmp_done", {31'h0, cmp_done}, {31'h0, slot == 3'h3});
    if (slot == 3'h3) check("cmp_result", cmp_result, exp);
  endtask
  // Checks done low one cycle early, so the latency is pinned exactly.
  task arith_case(input logic is_mul, input logic fl, input logic [2:0] slot,
      input logic [31:0] a, input logic [31:0] b, input logic [31:0] exp,
      input logic ok);
    @(posedge sys_clk);
    #1;
    {mul_valid, mul_slot, mul_flags_sel, mul_a, mul_b} =
      {is_mul, slot, fl, a, b};
    {sub_valid, sub_slot, sub_flags_sel, sub_a, sub_b} =
      {!is_mul, slot, fl, a, b};
    @(posedge sys_clk);
    #1;
    mul_valid = 1'b0;
    sub_valid = 1'b0;
    @(posedge sys_clk);
    #1;
    check("early_done", {31'h0, mul_done | sub_done}, 32'h0);
    @(posedge sys_clk);
    #1;
    check("done", {31'h0, is_mul ? mul_done : sub_done}, {31'h0, ok});
    if (ok) check("result", is_mul ? mul_result : sub_result, exp);
  endtask
  task sqrt_wait(input int start, input logic [31:0] exp);
    int n;
    // The cycle just after the issuing edge counts as the first.
    n = start + 1;
    while (sqrt_done !== 1'b1 && n < 40) begin
      @(posedge sys_clk);
      #1;
      n++;
    end
    check("sqrt_latency", n, 32'd17);
    check("sqrt_result", sqrt_result, exp);
  endtask
  task test_compare;
    cmp_case(2'h0, 1'b0, 3'h3, 32'h3f800000, 32'h40000000, 32'h0);
    cmp_case(2'h0, 1'b0, 3'h3, 32'h40000000, 32'h40000000, 32'h1);
    cmp_case(2'h0, 1'b0, 3'h3, 32'hc0000000, 32'h3f800000, 32'h0);
    cmp_case(2'h1, 1'b0, 3'h3, 32'h40000000, 32'h40000000, 32'h0);
    cmp_case(2'h1, 1'b0, 3'h3, 32'h3f800000, 32'hbf800000, 32'h1);
    cmp_case(2'h2, 1'b0, 3'h3, 32'h40000000, 32'h40000000, 32'h0);
    cmp_case(2'h2, 1'b0, 3'h3, 32'h00000000, 32'h80000000, 32'h0);
    cmp_case(2'h2, 1'b0, 3'h3, 32'h3f800000, 32'h40000000, 32'h1);
    cmp_case(2'h3, 1'b0, 3'h3, 32'hc0400000, 32'h0, 32'hffffffff);
    cmp_case(2'h3, 1'b0, 3'h3, 32'h00000000, 32'h0, 32'h0);
    cmp_case(2'h3, 1'b0, 3'h3, 32'h3f800000, 32'h0, 32'h1);
    cmp_case(2'h0, 1'b1, 3'h3, 32'h7fc00000, 32'h3f800000, 32'h10);
    cmp_case(2'h1, 1'b1, 3'h3, 32'h40000000, 32'h3f800000, 32'h0);
    cmp_case(2'h0, 1'b0, 3'h2, 32'h40000000, 32'h40000000, 32'h0);
  endtask
  task test_arith;
    arith_case(1, 0, 3'h2, 32'h40000000, 32'h40400000,
      32'h40c00000, 1);
    arith_case(1, 1, 3'h3, 32'h7f800000, 32'h0, 32'h10, 1);
    arith_case(1, 0, 3'h1, 32'h40000000, 32'h40400000, 32'h0, 0);
    arith_case(0, 0, 3'h1, 32'h40400000, 32'h3f800000,
      32'h40000000, 1);
    arith_case(0, 0, 3'h4, 32'h3f800000, 32'h40400000,
      32'hc0000000, 1);
    arith_case(0, 1, 3'h4, 32'h7f800000, 32'h7f800000, 32'h10, 1);
    arith_case(0, 0, 3'h2, 32'h40400000, 32'h3f800000, 32'h0, 0);
  endtask
  task test_sqrt;
    fco_issuer_inst.issue(1'b0, 32'h40800000, 1'b1);
    sqrt_wait(0, 32'h40000000);
    fco_issuer_inst.issue(1'b1, 32'hbf800000, 1'b1);
    sqrt_wait(0, 32'h10);
    fco_issuer_inst.issue(1'b1, 32'h40000000, 1'b1);
    sqrt_wait(0, 32'h1);
  endtask
  // A second root pushed into the recovery window must vanish without trace.
  task test_sqrt_refuse;
    int extra;
    extra = 0;
    fco_issuer_inst.issue(1'b0, 32'h40800000, 1'b1);
    check("sqrt_busy", {31'h0, sqrt_busy}, 32'h1);
    fco_issuer_inst.issue(1'b0, 32'h41100000, 1'b0);
    sqrt_wait(2, 32'h40000000);
    repeat (20) begin
      @(posedge sys_clk);
      #1;
      extra += (sqrt_done !== 1'b0);
    end
    check("sqrt_dropped", extra, 32'h0);
  endtask
  initial begin
    rst = 1'b1;
    {cmp_valid, cmp_flags_sel, mul_valid, mul_flags_sel} = 4'h0;
    {sub_valid, sub_flags_sel, cmp_slot, mul_slot, sub_slot} = 11'h0;
    {cmp_op, cmp_a, cmp_b, mul_a, mul_b, sub_a, sub_b} = 194'h0;
    repeat (2) @(posedge sys_clk);
    #1;
    rst = 1'b0;
    check("reset_busy", {31'h0, sqrt_busy | sqrt_done}, 32'h0);
    test_compare;
    test_arith;
    test_sqrt;
    test_sqrt_refuse;
    stop_test;
  end
  initial begin
    #100000;
    errors++;
    stop_test;
  end
endmodule
